//--- core/vmeic_decode.sv
/*
 Slave decode and access control of a bus carrier for four mezzanine
 slots: short I/O and standard space decode, width checks, interrupt
 pass-through with release on register access, and the APB register file.
 Assumes bus pins are asynchronous to pclk and held stable by the master
 from address strobe until data strobes release, as the bus requires.
*/
`timescale 1ns/100ps
module vmeic_decode
    import vmeic_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              vme_as_n,
    input  wire logic [1:0]        vme_ds_n,
    input  wire logic              vme_write_n,
    input  wire logic              vme_lword_n,
    input  wire logic              vme_iack_n,
    input  wire logic [5:0]        vme_am,
    input  wire logic [23:1]       vme_addr,
    input  wire logic [5:0]        base_address_jumpers,
    input  wire logic [IRQS-1:0]   ip_irq_n,
    output logic                   vme_dtack_n,
    output logic [7:1]             vme_irq_n,
    output logic [15:0]            vme_data_out,
    output logic                   vme_data_oe,
    output logic                   acc_strobe,
    output logic                   acc_write,
    output logic [1:0]             acc_lane,
    output logic [23:1]            acc_addr,
    output logic                   carrier_sel,
    output logic [SLOTS-1:0]       ip_id_sel,
    output logic [SLOTS-1:0]       ip_io_sel,
    output logic [SLOTS-1:0]       ip_mem_sel
);
    localparam int SW = 49;

    // Two-flop synchronisers for every pin
    logic [SW-1:0]      pin_meta;
    logic [SW-1:0]      pin_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= {vme_as_n, vme_ds_n, vme_write_n, vme_lword_n,
                         vme_iack_n, vme_am, vme_addr,
                         base_address_jumpers, ip_irq_n};
            pin_sync <= pin_meta;
        end
    end

    wire                as_n    = pin_sync[48];
    wire [1:0]          ds_n    = pin_sync[47:46];
    wire                wr_n    = pin_sync[45];
    wire                lword_n = pin_sync[44];
    wire                iack_n  = pin_sync[43];
    wire [5:0]          am      = pin_sync[42:37];
    wire [23:1]         addr    = pin_sync[36:14];
    wire [5:0]          jumpers = pin_sync[13:8];
    wire [IRQS-1:0]     irq_req = ~pin_sync[7:0];

    // Registers written by software, and the hardware-set int_stat and irq_hold
    logic [2:0]         level;
    logic [7:0]         vector;
    logic [SLOTS-1:0]   mem_en;
    logic [15:0]        mem_base;
    logic [7:0]         mem_size;
    logic [IRQS-1:0]    irq_en;
    logic [EVENTS-1:0]  int_stat;
    logic [EVENTS-1:0]  int_mask;
    logic               irq_hold;

    // Cycle tracking
    vmeic_cyc_type      cyc;
    vmeic_space_type    space;
    logic [1:0]         slot;
    logic               as_prev;
    logic               ds_prev_idle;
    logic               ds_seen;

    wire as_fall  = as_prev && !as_n;
    wire ds_idle  = &ds_n;
    wire ds_start = ds_prev_idle && !ds_idle;

    // Modifier and block decode
    wire short_am = (am == AM_SHORT_USR) || (am == AM_SHORT_SUP);
    wire std_am   = (am == AM_STD_USR) || (am == AM_STD_SUP);
    // Installed jumper reads one, so the base is the jumper word itself
    wire blk_hit  = short_am && (addr[15:BLK_LSB] == jumpers);
    wire [1:0] region = addr[9:8];
    wire iack_hit = !iack_n && irq_hold && (level != 3'h0)
                    && (addr[3:1] == level);

    // Standard space window per slot; base must be aligned to its size
    logic [SLOTS-1:0] mem_hit;
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_mem
            wire [3:0] base_nib = mem_base[4*gi +: 4];
            wire [1:0] size_cod = mem_size[2*gi +: 2];
            wire [3:0] win_mask = 4'hf << size_cod;
            assign mem_hit[gi] = std_am && mem_en[gi] &&
                ((addr[23:MEM_LSB] & win_mask) == (base_nib & win_mask));
        end
    endgenerate

    // Lowest slot wins when programmed windows overlap
    wire [1:0] mem_slot = mem_hit[0] ? 2'd0 : mem_hit[1] ? 2'd1 :
                          mem_hit[2] ? 2'd2 : 2'd3;
    wire short_hit = iack_n && blk_hit;
    wire any_hit   = iack_hit || short_hit || (iack_n && |mem_hit);
    wire vmeic_space_type hit_space =
        iack_hit                   ? SP_IACK :
        !short_hit                 ? SP_MEM :
        region == REG_CARRIER      ? SP_CARRIER :
        region == REG_ID           ? SP_ID : SP_IO;
    wire [1:0] hit_slot = !short_hit ? mem_slot :
                          region[1] ? {region[0], addr[7]} : addr[7:6];

    // Width check: no 32-bit, even-only byte refused on D08(O) spaces
    wire odd_only = (space == SP_CARRIER) || (space == SP_ID)
                    || (space == SP_IACK);
    wire width_ok = lword_n && !(odd_only && ds_n == 2'b01);
    wire take     = (cyc == CYC_OWN) && ds_start && width_ok;

    // Cycle state: claim at address strobe, drop when it rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc   <= CYC_IDLE;
            space <= SP_CARRIER;
            slot  <= 2'd0;
        end else if (as_n) begin
            cyc   <= CYC_IDLE;
        end else if (as_fall) begin
            cyc   <= any_hit ? CYC_OWN : CYC_SKIP;
            space <= hit_space;
            slot  <= hit_slot;
        end
    end

    // Strobe edge history; several strobes under one address is RMW
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            as_prev      <= 1'b1;
            ds_prev_idle <= 1'b1;
            ds_seen      <= 1'b0;
        end else begin
            as_prev      <= as_n;
            ds_prev_idle <= ds_idle;
            ds_seen      <= as_n ? 1'b0 : (ds_seen || take);
        end
    end

    // Acknowledge held until both data strobes release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vme_dtack_n  <= 1'b1;
            vme_data_oe  <= 1'b0;
            vme_data_out <= 16'h0000;
        end else if (take) begin
            vme_dtack_n  <= 1'b0;
            vme_data_oe  <= (space == SP_IACK);
            vme_data_out <= {8'h00, vector};
        end else if (ds_idle || cyc != CYC_OWN) begin
            vme_dtack_n  <= 1'b1;
            vme_data_oe  <= 1'b0;
        end
    end

    // Access qualifiers to the slot side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_strobe  <= 1'b0;
            acc_write   <= 1'b0;
            acc_lane    <= 2'b00;
            acc_addr    <= '0;
            carrier_sel <= 1'b0;
            ip_id_sel   <= '0;
            ip_io_sel   <= '0;
            ip_mem_sel  <= '0;
        end else begin
            acc_strobe  <= take && (space != SP_IACK);
            if (take) begin
                acc_write <= !wr_n;
                acc_lane  <= ~ds_n;
                acc_addr  <= addr;
            end
            carrier_sel <= take ? (space == SP_CARRIER) : carrier_sel
                           && !ds_idle;
            ip_id_sel   <= take && space == SP_ID ? 4'b0001 << slot :
                           ds_idle ? '0 : ip_id_sel;
            ip_io_sel   <= take && space == SP_IO ? 4'b0001 << slot :
                           ds_idle ? '0 : ip_io_sel;
            ip_mem_sel  <= take && space == SP_MEM ? 4'b0001 << slot :
                           ds_idle ? '0 : ip_mem_sel;
        end
    end

    // APB decode; answer comes one cycle into the access phase
    wire apb_go   = psel && penable && !pready;
    wire apb_wr   = apb_go && pwrite;
    wire w_ctrl   = apb_wr && paddr == OFS_CTRL;
    wire w_mem_en = apb_wr && paddr == OFS_MEM_EN;
    wire w_base   = apb_wr && paddr == OFS_MEM_BASE;
    wire w_size   = apb_wr && paddr == OFS_MEM_SIZE;
    wire w_irq_en = apb_wr && paddr == OFS_IRQ_EN;
    wire w_istat  = apb_wr && paddr == OFS_INT_STAT;
    wire w_imask  = apb_wr && paddr == OFS_INT_MASK;
    wire [IRQS-1:0] irq_pend = irq_req & irq_en;
    wire mapped   = paddr == OFS_CTRL || paddr == OFS_MEM_EN ||
                    paddr == OFS_MEM_BASE || paddr == OFS_MEM_SIZE ||
                    paddr == OFS_IRQ_EN || paddr == OFS_IRQ_PEND ||
                    paddr == OFS_STATUS || paddr == OFS_INT_STAT ||
                    paddr == OFS_INT_MASK;
    wire [31:0] rd_mux =
        paddr == OFS_CTRL     ? {16'h0000, vector, 5'h00, level} :
        paddr == OFS_MEM_EN   ? {28'h0000000, mem_en} :
        paddr == OFS_MEM_BASE ? {16'h0000, mem_base} :
        paddr == OFS_MEM_SIZE ? {24'h000000, mem_size} :
        paddr == OFS_IRQ_EN   ? {24'h000000, irq_en} :
        paddr == OFS_IRQ_PEND ? {24'h000000, irq_pend} :
        paddr == OFS_STATUS   ? {16'h0000, irq_hold, 1'b0, jumpers,
                                 8'h00} :
        paddr == OFS_INT_STAT ? {29'h0, int_stat} :
        paddr == OFS_INT_MASK ? {29'h0, int_mask} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_go;
            prdata  <= apb_go && !pwrite ? rd_mux : 32'h00000000;
            pslverr <= apb_go && !mapped;
        end
    end

    // Software registers; reset leaves memory and requests disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level    <= RST_LEVEL;
            vector   <= RST_VECTOR;
            mem_en   <= RST_MEM_EN;
            mem_base <= 16'h0000;
            mem_size <= 8'h00;
            irq_en   <= RST_IRQ_EN;
            int_mask <= '0;
        end else begin
            if (w_ctrl) begin
                level  <= pwdata[CTRL_LVL_LSB +: 3];
                vector <= pwdata[CTRL_VEC_LSB +: 8];
            end
            if (w_mem_en)
                mem_en <= pwdata[SLOTS-1:0];
            if (w_base)
                mem_base <= pwdata[15:0];
            if (w_size)
                mem_size <= pwdata[7:0];
            if (w_irq_en)
                irq_en <= pwdata[IRQS-1:0];
            if (w_imask)
                int_mask <= pwdata[EVENTS-1:0];
        end
    end

    // Sticky events; a new event in the clearing cycle survives
    wire [EVENTS-1:0] ev_set;
    assign ev_set[EV_REFUSED] = (cyc == CYC_OWN) && ds_start && !width_ok;
    assign ev_set[EV_IACK]    = take && (space == SP_IACK);
    assign ev_set[EV_RMW]     = take && ds_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= '0;
            irq      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~({EVENTS{w_istat}}
                        & pwdata[EVENTS-1:0])) | ev_set;
            irq      <= |(int_stat & int_mask);
        end
    end

    // Release on register access: acknowledge alone does not drop it
    wire reg_touch = apb_go || (take && space == SP_CARRIER);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_hold <= 1'b0;
        end else if (|irq_pend) begin
            irq_hold <= 1'b1;
        end else if (reg_touch) begin
            irq_hold <= 1'b0;
        end
    end

    // One bus level driven, none while level reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vme_irq_n <= 7'h7f;
        end else begin
            for (int l = 1; l < 8; l++)
                vme_irq_n[l] <= !(irq_hold && level == l[2:0]);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_claim;
        as_fall && short_hit && !iack_hit;
    endsequence
    sequence s_strobe;
        take;
    endsequence

    short_claim_a: assert property (s_claim |=> cyc == CYC_OWN)
        else $error("short cycle in window not claimed");
    miss_quiet_a: assert property (cyc == CYC_SKIP |-> vme_dtack_n)
        else $error("acknowledge on a cycle outside windows");
    jumper_base_a: assert property (carrier_sel |->
        acc_addr[15:10] == jumpers)
        else $error("carrier select with wrong base");
    mem_gate_a: assert property (|ip_mem_sel |-> |mem_en)
        else $error("memory select while memory disabled");
    odd_byte_a: assert property (carrier_sel && !vme_dtack_n |->
        acc_lane != 2'b10)
        else $error("even byte access to carrier registers");
    rmw_ack_a: assert property (s_strobe |=> !vme_dtack_n ##1
        (!vme_dtack_n || ds_idle))
        else $error("strobe not acknowledged");
    no_own_irq_a: assert property (!irq_hold |=> &vme_irq_n)
        else $error("bus request without slot request");
    release_on_access_scheme_hold_a: assert property (irq_hold && !reg_touch |=>
        irq_hold)
        else $error("request dropped without register access");
    vector_out_a: assert property (s_strobe ##0 space == SP_IACK |=>
        vme_data_oe && vme_data_out[7:0] == vector)
        else $error("vector not driven on acknowledge");
endmodule

//--- core/vmeic_pkg.sv
/*
 Constants of the carrier slave decode: bus modifiers, short I/O layout,
 APB register map, field positions and reset values.
 Assumes one clock and an APB master reaching the register words.
*/
package vmeic_pkg;
    localparam int          SLOTS        = 4;
    localparam int          IRQS         = 2 * SLOTS;
    // Address modifiers
    localparam logic [5:0]  AM_SHORT_USR = 6'h29;
    localparam logic [5:0]  AM_SHORT_SUP = 6'h2d;
    localparam logic [5:0]  AM_STD_USR   = 6'h39;
    localparam logic [5:0]  AM_STD_SUP   = 6'h3d;
    // Short block: A15..A10 select, A9..A8 choose the region
    localparam int          BLK_LSB      = 10;
    localparam logic [1:0]  REG_CARRIER  = 2'h0;
    localparam logic [1:0]  REG_ID       = 2'h1;
    localparam int          MEM_LSB      = 20;
    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_MEM_EN   = 8'h04;
    localparam logic [7:0]  OFS_MEM_BASE = 8'h08;
    localparam logic [7:0]  OFS_MEM_SIZE = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_PEND = 8'h14;
    localparam logic [7:0]  OFS_STATUS   = 8'h18;
    localparam logic [7:0]  OFS_INT_STAT = 8'h1c;
    localparam logic [7:0]  OFS_INT_MASK = 8'h20;
    // Field positions inside CTRL
    localparam int          CTRL_LVL_LSB = 0;
    localparam int          CTRL_VEC_LSB = 8;
    // Event bits of INT_STAT / INT_MASK
    localparam int          EV_REFUSED   = 0;
    localparam int          EV_IACK      = 1;
    localparam int          EV_RMW       = 2;
    localparam int          EVENTS       = 3;
    // Reset values
    localparam logic [2:0]  RST_LEVEL    = 3'h0;
    localparam logic [7:0]  RST_VECTOR   = 8'h00;
    localparam logic [3:0]  RST_MEM_EN   = 4'h0;
    localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
    localparam int          CLK_PERIOD_NS = 25;
    typedef enum logic [1:0] {CYC_IDLE, CYC_OWN, CYC_SKIP} vmeic_cyc_type;
    typedef enum logic [2:0] {SP_CARRIER, SP_ID, SP_IO, SP_MEM, SP_IACK}
        vmeic_space_type;
endpackage

//--- tb/vmeic_vme_master.sv
/*
 Behavioural bus master standing on the far side of the decode block.
 Assumes one pclk; pins change just after a rising edge and the
 acknowledge is sampled on rising edges under a bounded wait.
*/
`timescale 1ns/100ps
module vmeic_vme_master (
    input  wire logic        pclk,
    input  wire logic        vme_dtack_n,
    output logic             vme_as_n,
    output logic [1:0]       vme_ds_n,
    output logic             vme_write_n,
    output logic             vme_lword_n,
    output logic             vme_iack_n,
    output logic [5:0]       vme_am,
    output logic [23:1]      vme_addr
);
    // Idle bus: strobes high, address parked on a junk value
    initial begin
        vme_as_n = 1'b1;
        vme_ds_n = 2'b11;
        vme_write_n = 1'b1;
        vme_lword_n = 1'b1;
        vme_iack_n = 1'b1;
        vme_am = 6'h3f;
        vme_addr = '1;
    end

    // Bounded wait, so a silent slave never hangs the master
    task automatic wait_dtack(input logic lvl, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 16 && !seen; i++) begin
            @(posedge pclk);
            seen = (vme_dtack_n === lvl);
        end
    endtask

    // One cycle; with rmw the address strobe spans two data strobes
    task automatic bus_cycle(input logic [5:0] m, input logic [23:1] a,
                             input logic [1:0] ds, input logic wr,
                             input logic ia, input logic rmw,
                             output logic [1:0] acks);
        logic seen;
        acks = 2'b00;
        @(posedge pclk);
        vme_am <= m;
        vme_addr <= a;
        vme_write_n <= ~wr;
        vme_iack_n <= ~ia;
        @(posedge pclk);
        vme_as_n <= 1'b0;
        repeat (3) @(posedge pclk);
        for (int k = 0; k < (rmw ? 2 : 1); k++) begin
            vme_ds_n <= ds;
            wait_dtack(1'b0, seen);
            acks[k] = seen;
            vme_ds_n <= 2'b11;
            wait_dtack(1'b1, seen);
            @(posedge pclk);
        end
        vme_as_n <= 1'b1;
        vme_iack_n <= 1'b1;
        @(posedge pclk);
        // Released lines must not keep the old address
        vme_am <= ~m;
        vme_addr <= ~a;
        repeat (3) @(posedge pclk);
    endtask
endmodule

//--- tb/vme_ip_carrier_slave_decode_tb.sv
/*
 Self-checking bench of the carrier slave decode: APB register access,
 short and standard decode, widths, RMW and interrupt pass-through.
 Assumes the bus master model and the package are compiled first.
*/
`timescale 1ns/100ps
module vme_ip_carrier_slave_decode_tb
    import vmeic_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, apb_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic vme_as_n, vme_write_n, vme_lword_n, vme_iack_n, vme_dtack_n;
    logic [1:0] vme_ds_n, acc_lane, acks;
    logic [5:0] vme_am, base_address_jumpers;
    logic [23:1] vme_addr, acc_addr;
    logic [IRQS-1:0] ip_irq_n;
    logic [7:1] vme_irq_n;
    logic [15:0] vme_data_out, vec_seen;
    logic vme_data_oe, acc_strobe, acc_write, carrier_sel;
    logic [SLOTS-1:0] ip_id_sel, ip_io_sel, ip_mem_sel;
    logic [12:0] sel_seen;
    logic [2:0] acc_seen;
    int error_cnt = 0;
    int n_tests = 0;

    always #12.5 pclk = ~pclk;

    vmeic_decode vmeic_decode_inst (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .vme_as_n(vme_as_n),
        .vme_ds_n(vme_ds_n), .vme_write_n(vme_write_n),
        .vme_lword_n(vme_lword_n), .vme_iack_n(vme_iack_n),
        .vme_am(vme_am), .vme_addr(vme_addr),
        .base_address_jumpers(base_address_jumpers),
        .ip_irq_n(ip_irq_n), .vme_dtack_n(vme_dtack_n),
        .vme_irq_n(vme_irq_n), .vme_data_out(vme_data_out),
        .vme_data_oe(vme_data_oe), .acc_strobe(acc_strobe),
        .acc_write(acc_write), .acc_lane(acc_lane), .acc_addr(acc_addr),
        .carrier_sel(carrier_sel), .ip_id_sel(ip_id_sel),
        .ip_io_sel(ip_io_sel), .ip_mem_sel(ip_mem_sel));

    vmeic_vme_master vmeic_vme_master_inst (.pclk(pclk),
        .vme_dtack_n(vme_dtack_n), .vme_as_n(vme_as_n),
        .vme_ds_n(vme_ds_n), .vme_write_n(vme_write_n),
        .vme_lword_n(vme_lword_n), .vme_iack_n(vme_iack_n),
        .vme_am(vme_am), .vme_addr(vme_addr));

    // Selects and vector held while acknowledged, judged after the cycle
    always @(posedge pclk) begin
        if (vme_dtack_n === 1'b0) begin
            sel_seen <= {carrier_sel, ip_id_sel, ip_io_sel, ip_mem_sel};
        end
        if (vme_data_oe === 1'b1 && vme_dtack_n === 1'b0) begin
            vec_seen <= vme_data_out;
        end
        // Direction and lanes of the last strobe passed to the carrier or a slot
        if (acc_strobe === 1'b1) begin
            acc_seen <= {acc_write, acc_lane};
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; waits for pready under a bounded count
    task automatic apb(input logic [7:0] a, input logic wr,
                       input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge pclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        d = prdata;
        apb_err = pslverr;
        check("apb ready", {31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [23:1] ba(input logic [23:0] x);
        return x[23:1];
    endfunction

    // Data cycle that either must or must not be acknowledged
    task automatic vacc(input logic [5:0] m, input logic [23:1] a,
                        input logic [1:0] ds, input logic ack,
                        input logic [12:0] sel);
        vmeic_vme_master_inst.bus_cycle(m, a, ds, 1'b0, 1'b0, 1'b0, acks);
        check("ack", {31'h0, acks[0]}, {31'h0, ack});
        if (ack) begin
            check("select", {19'h0, sel_seen}, {19'h0, sel});
        end
    endtask

    task automatic t_reset;
        apb(OFS_CTRL, 1'b0, 32'h0, rd);
        check("ctrl", rd, 32'h0);
        apb(OFS_MEM_EN, 1'b0, 32'h0, rd);
        check("mem_en", rd, 32'h0);
        apb(OFS_IRQ_EN, 1'b0, 32'h0, rd);
        check("irq_en", rd, 32'h0);
        apb(8'h30, 1'b0, 32'h0, rd);
        check("unmapped", {31'h0, apb_err}, 32'h1);
        check("bus req", {25'h0, vme_irq_n}, 32'h7f);
        $display("test reset done");
    endtask

    task automatic t_short;
        logic [15:0] bt [3] = '{16'h0400, 16'hfc00, 16'h0000};
        logic [5:0] jt [3] = '{6'h01, 6'h3f, 6'h00};
        foreach (bt[i]) begin
            base_address_jumpers <= jt[i];
            repeat (4) @(posedge pclk);
            apb(OFS_STATUS, 1'b0, 32'h0, rd);
            check("jumpers", {26'h0, rd[13:8]}, {26'h0, jt[i]});
            vacc(AM_SHORT_USR, ba({8'h0, bt[i]}), 2'b00, 1, 13'h1000);
            vacc(AM_SHORT_SUP, ba({8'h0, bt[i]} + 24'h3fe), 2'b00, 1,
                 13'h0080);
            vacc(AM_SHORT_USR, ba({8'h0, bt[i] ^ 16'h0400}), 2'b00, 0,
                 13'h0);
            vacc(6'h09, ba({8'h0, bt[i]}), 2'b00, 1'b0, 13'h0);
        end
        $display("test short decode done");
    endtask

    task automatic t_space;
        for (int s = 0; s < SLOTS; s++) begin
            vacc(AM_SHORT_USR, ba(24'h200 + 24'(s * 128)), 2'b01, 1'b1,
                 13'(16 << s));
            vacc(AM_SHORT_SUP, ba(24'h100 + 24'(s * 64)), 2'b10, 1'b1,
                 13'(256 << s));
            vacc(AM_SHORT_SUP, ba(24'h100 + 24'(s * 64)), 2'b01, 1'b0,
                 13'h0);
        end
        vacc(AM_SHORT_USR, ba(24'h002), 2'b10, 1'b1, 13'h1000);
        check("acc lane", {29'h0, acc_seen}, 32'h1);
        vacc(AM_SHORT_USR, ba(24'h002), 2'b01, 1'b0, 13'h0);
        apb(OFS_INT_STAT, 1'b0, 32'h0, rd);
        check("width event", {31'h0, rd[EV_REFUSED]}, 32'h1);
        $display("test spaces done");
    endtask

    task automatic t_mem;
        vacc(AM_STD_USR, ba(24'h200000), 2'b00, 1'b0, 13'h0);
        apb(OFS_MEM_BASE, 1'b1, 32'h30, rd);
        apb(OFS_MEM_SIZE, 1'b1, 32'h4, rd);
        apb(OFS_MEM_EN, 1'b1, 32'h2, rd);
        vacc(AM_STD_USR, ba(24'h200000), 2'b00, 1'b1, 13'h0002);
        vacc(AM_STD_SUP, ba(24'h3ffffe), 2'b01, 1'b1, 13'h0002);
        vacc(AM_STD_SUP, ba(24'h400000), 2'b00, 1'b0, 13'h0);
        vacc(AM_STD_USR, ba(24'h1ffffe), 2'b00, 1'b0, 13'h0);
        apb(OFS_MEM_SIZE, 1'b1, 32'hc, rd);
        vacc(AM_STD_USR, ba(24'h7ffffe), 2'b10, 1'b1, 13'h0002);
        vacc(AM_STD_USR, ba(24'h800000), 2'b00, 1'b0, 13'h0);
        apb(OFS_MEM_EN, 1'b1, 32'h0, rd);
        vacc(AM_STD_USR, ba(24'h200000), 2'b00, 1'b0, 13'h0);
        $display("test memory done");
    endtask

    task automatic t_rmw;
        vmeic_vme_master_inst.bus_cycle(AM_SHORT_USR, ba(24'h10), 2'b00,
                                        1'b1, 1'b0, 1'b1, acks);
        check("rmw acks", {30'h0, acks}, 32'h3);
        check("acc qual", {29'h0, acc_seen}, 32'h7);
        apb(OFS_INT_STAT, 1'b0, 32'h0, rd);
        check("rmw event", rd, 32'h5);
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(OFS_INT_MASK, 1'b1, 32'h4, rd);
        repeat (2) @(posedge pclk);
        check("irq up", {31'h0, irq}, 32'h1);
        apb(OFS_INT_STAT, 1'b1, 32'h5, rd);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test rmw done");
    endtask

    task automatic t_irq;
        ip_irq_n <= 8'hf7;
        repeat (6) @(posedge pclk);
        check("no request", {25'h0, vme_irq_n}, 32'h7f);
        apb(OFS_IRQ_EN, 1'b1, 32'h08, rd);
        apb(OFS_IRQ_PEND, 1'b0, 32'h0, rd);
        check("pending", rd, 32'h08);
        for (int l = 1; l < 8; l++) begin
            apb(OFS_CTRL, 1'b1, 32'(l), rd);
            repeat (3) @(posedge pclk);
            check("level", {25'h0, vme_irq_n},
                  {25'h0, ~(7'h1 << (l - 1))});
        end
        apb(OFS_CTRL, 1'b1, 32'ha505, rd);
        vmeic_vme_master_inst.bus_cycle(AM_SHORT_SUP, ba(24'h6), 2'b10,
                                        1'b0, 1'b1, 1'b0, acks);
        check("wrong level ack", {31'h0, acks[0]}, 32'h0);
        vmeic_vme_master_inst.bus_cycle(AM_SHORT_SUP, ba(24'ha), 2'b10,
                                        1'b0, 1'b1, 1'b0, acks);
        check("iack ack", {31'h0, acks[0]}, 32'h1);
        check("vector", {16'h0, vec_seen}, 32'h00a5);
        ip_irq_n <= 8'hff;
        repeat (6) @(posedge pclk);
        check("held", {25'h0, vme_irq_n}, 32'h6f);
        apb(OFS_CTRL, 1'b0, 32'h0, rd);
        repeat (3) @(posedge pclk);
        check("released", {25'h0, vme_irq_n}, 32'h7f);
        ip_irq_n <= 8'hfe;
        repeat (6) @(posedge pclk);
        check("disabled slot", {25'h0, vme_irq_n}, 32'h7f);
        ip_irq_n <= 8'hff;
        $display("test interrupts done");
    endtask

    // Watchdog at 80000 cycles, well beyond the thousand or so cycles the tests need
    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        base_address_jumpers = 6'h00;
        ip_irq_n = 8'hff;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset;
        t_short;
        t_space;
        t_mem;
        t_rmw;
        t_irq;
        tally_and_finish;
    end
endmodule
